// ==== src/mpdc_pkg.sv ====
// Operation
// - Display page code is 22h, top bits zero
// - Display page length byte must be 52h
// - Flag 0 internal text, 1 host text
// - Flags in byte 2 bits 3..0, rest zero
// - Line texts are 20-byte fields, bytes 4-83
// - Own default for line two is blank
// - Configuration page code is 3Dh, top bits zero
// - Configuration page length byte must be 28h
// - Write flag bit 7: alter, else select
// - Alter only with valid fields and alterable variable
// - Type codes 0..3 must match variable type
// - Text length zero means zero-terminated, max 16
// - Byte array length is count, max 16
// - Signed integers 1/2/4 bytes, MSB first
// - Unsigned integers 1/2/4 bytes, MSB first
// - Name zero-terminated at byte 4, max 20
// - Alter requires exact existing name match
// - Empty name selects the first variable
// - Remember latest selection for next mode sense
package mpdc_pkg;
	// Page identification
	localparam logic [5:0] PAGE_DISP = 6'h22;
	localparam logic [5:0] PAGE_CFG = 6'h3D;
	localparam logic [7:0] LEN_DISP = 8'h52;
	localparam logic [7:0] LEN_CFG = 8'h28;
	// Byte positions within a page
	localparam logic [6:0] POS_LEN = 7'h01;
	localparam logic [6:0] LAST_DISP = 7'h53;
	localparam logic [6:0] LAST_CFG = 7'h29;
	localparam int BUF_BYTES = 84;
	localparam int TEXT_BASE = 4;
	localparam int LINE_CHARS = 20;
	localparam int LINES = 4;
	localparam int NAME_BASE = 4;
	localparam int NAME_MAX = 20;
	localparam int NAME_TERM = 24;
	localparam int VAL_BASE = 25;
	localparam int VAL_MAX = 16;
	localparam int VAL_TERM = 41;
	// Field positions in byte 2 of the configuration page
	localparam int WR_BIT = 7;
	localparam int TYPE_LSB = 5;
	localparam int LEN_LSB = 0;
	// Value type codes
	localparam logic [1:0] TY_TEXT = 2'h0;
	localparam logic [1:0] TY_BYTES = 2'h1;
	localparam logic [1:0] TY_SINT = 2'h2;
	localparam logic [1:0] TY_UINT = 2'h3;
	localparam logic [7:0] CHAR_BLANK = 8'h20;
	// Register offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_SEL = 12'h008;
	localparam logic [11:0] OFF_OVR = 12'h00C;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [5:0] STATUS_RST = 6'h00;
	// Status bit positions
	localparam int ST_DISP_DONE = 0;
	localparam int ST_CFG_DONE = 1;
	localparam int ST_BAD_CODE = 2;
	localparam int ST_BAD_LEN = 3;
	localparam int ST_BAD_FIELD = 4;
	localparam int ST_REJECT = 5;

	typedef struct packed {
		logic found;
		logic alterable;
		logic [7:0] idx;
		logic [1:0] vtype;
	} mpdc_lookup_t;

	typedef struct packed {
		logic [7:0] idx;
		logic [1:0] vtype;
		logic [4:0] len;
		logic [127:0] bytes;
		logic [31:0] ival;
	} mpdc_var_wr_t;
endpackage : mpdc_pkg

// ==== src/mpdc_parser.sv ====
`timescale 1ns/1ps
module mpdc_parser (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic pg_vld_i,
	input wire logic pg_first_i,
	input wire logic [7:0] pg_byte_i,
	output logic pg_rdy_o,
	output logic lookup_req_o,
	output logic [159:0] lookup_name_o,
	input wire logic lookup_ack_i,
	input wire mpdc_pkg::mpdc_lookup_t lookup_rsp_i,
	output logic var_wr_vld_o,
	output mpdc_pkg::mpdc_var_wr_t var_wr_o,
	output logic [7:0] sel_idx_o,
	output logic sel_valid_o,
	input wire logic [1:0] disp_line_i,
	input wire logic [4:0] disp_col_i,
	input wire logic [7:0] int_char_i,
	output logic [7:0] disp_char_o
);
	import mpdc_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_COLLECT, S_CHECK, S_LOOKUP} mpdc_state_t;

	mpdc_state_t state_q, state_d;
	logic [7:0] buf_q [BUF_BYTES];
	logic [7:0] buf_d [BUF_BYTES];
	logic [7:0] disp_q [LINES*LINE_CHARS];
	logic [7:0] disp_d [LINES*LINE_CHARS];
	logic [6:0] cnt_q, cnt_d;
	logic is_cfg_q, is_cfg_d;
	logic [3:0] ovr_q, ovr_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [5:0] status_q, status_d, st_set;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic pg_rdy_q, pg_rdy_d, lookup_req_q, lookup_req_d, var_wr_vld_q, var_wr_vld_d;
	logic [159:0] name_q, name_d;
	mpdc_var_wr_t var_wr_q, var_wr_d;
	logic [7:0] sel_idx_q, sel_idx_d;
	logic sel_valid_q, sel_valid_d;
	logic [7:0] disp_char_q, disp_char_d;
	logic accept, term, name_end;
	logic [7:0] b;
	logic [4:0] eff_len, len_f;
	logic [1:0] type_f;
	logic wr_f, len_ok, fields_ok, name_empty;
	logic [127:0] val_bytes;
	logic [31:0] ival;
	logic [6:0] pos;

	assign accept = pg_vld_i && pg_rdy_q;
	// Configuration field decode from byte 2, empty-name test on byte 4
	assign wr_f = buf_q[2][WR_BIT];
	assign type_f = buf_q[2][TYPE_LSB +: 2];
	assign len_f = buf_q[2][LEN_LSB +: 5];
	assign name_empty = (buf_q[NAME_BASE] == 8'h00);

	// Text length of a zero-terminated value: first zero in the value field, 16 if bytes 25-40 hold none
	always_comb begin
		eff_len = 5'(VAL_MAX);
		for (int k = VAL_MAX - 1; k >= 0; k--) begin
			if (buf_q[VAL_BASE + k] == 8'h00) begin
				eff_len = 5'(k);
			end
		end
		if (!(type_f == TY_TEXT && len_f == 5'h00)) begin
			eff_len = len_f;
		end
	end

	// Value bytes past the supplied length read as zero, first byte on top
	for (genvar k = 0; k < VAL_MAX; k++) begin : g_val
		assign val_bytes[127 - 8*k -: 8] = (5'(k) < eff_len) ? buf_q[VAL_BASE + k] : 8'h00;
	end

	// Integer value, most significant byte first
	always_comb begin
		ival = 32'h0000_0000;
		case (len_f)
			5'h01: ival = {{24{type_f == TY_SINT && buf_q[VAL_BASE][7]}}, buf_q[VAL_BASE]};
			5'h02: ival = {{16{type_f == TY_SINT && buf_q[VAL_BASE][7]}}, buf_q[VAL_BASE],
				buf_q[VAL_BASE+1]};
			5'h04: ival = {buf_q[VAL_BASE], buf_q[VAL_BASE+1], buf_q[VAL_BASE+2], buf_q[VAL_BASE+3]};
			default: ival = 32'h0000_0000;
		endcase
	end

	// Length legality per type
	always_comb begin
		case (type_f)
			TY_TEXT: len_ok = (len_f <= 5'(VAL_MAX));
			TY_BYTES: len_ok = (len_f != 5'h00) && (len_f <= 5'(VAL_MAX));
			default: len_ok = (len_f == 5'h01) || (len_f == 5'h02) || (len_f == 5'h04);
		endcase
	end

	// Zero bytes the page demands; a wrong one rejects the whole page
	always_comb begin
		if (is_cfg_q) begin
			fields_ok = (buf_q[3] == 8'h00) && (buf_q[NAME_TERM] == 8'h00) && (buf_q[VAL_TERM] == 8'h00);
		end else begin
			fields_ok = (buf_q[2][7:4] == 4'h0) && (buf_q[3] == 8'h00);
		end
	end

	// Host text per line, blanked from the first zero on
	always_comb begin
		term = 1'b0;
		b = 8'h00;
		for (int l = 0; l < LINES; l++) begin
			term = 1'b0;
			for (int c = 0; c < LINE_CHARS; c++) begin
				b = buf_q[TEXT_BASE + l*LINE_CHARS + c];
				if (b == 8'h00) begin
					term = 1'b1;
				end
				disp_d[l*LINE_CHARS + c] = (state_q == S_CHECK && !is_cfg_q && fields_ok) ?
					(term ? CHAR_BLANK : b) : disp_q[l*LINE_CHARS + c];
			end
		end
	end

	// Name presented for lookup, bytes after the terminator cleared
	always_comb begin
		name_end = 1'b0;
		name_d = name_q;
		for (int k = 0; k < NAME_MAX; k++) begin
			if (buf_q[NAME_BASE + k] == 8'h00) begin
				name_end = 1'b1;
			end
			if (state_q == S_CHECK) begin
				name_d[159 - 8*k -: 8] = name_end ? 8'h00 : buf_q[NAME_BASE + k];
			end
		end
	end

	// Page parser state machine
	always_comb begin
		state_d = state_q;
		buf_d = buf_q;
		cnt_d = cnt_q;
		is_cfg_d = is_cfg_q;
		ovr_d = ovr_q;
		st_set = 6'h00;
		lookup_req_d = 1'b0;
		var_wr_vld_d = 1'b0;
		var_wr_d = var_wr_q;
		sel_idx_d = sel_idx_q;
		sel_valid_d = sel_valid_q;
		pg_rdy_d = ctrl_q[0] && (state_d == S_IDLE || state_d == S_COLLECT);
		pos = cnt_q;
		case (state_q)
			S_IDLE: begin
				if (accept && pg_first_i) begin
					buf_d[0] = pg_byte_i;
					cnt_d = POS_LEN;
					is_cfg_d = (pg_byte_i[5:0] == PAGE_CFG);
					if (pg_byte_i == {2'b00, PAGE_DISP} || pg_byte_i == {2'b00, PAGE_CFG}) begin
						state_d = S_COLLECT;
					end else begin
						st_set[ST_BAD_CODE] = 1'b1;
					end
				end
			end
			S_COLLECT: begin
				if (accept) begin
					buf_d[pos] = pg_byte_i;
					cnt_d = cnt_q + 7'h01;
					if (pg_first_i) begin
						st_set[ST_BAD_LEN] = 1'b1;
						state_d = S_IDLE;
					end else if (cnt_q == POS_LEN && pg_byte_i != (is_cfg_q ? LEN_CFG : LEN_DISP)) begin
						st_set[ST_BAD_LEN] = 1'b1;
						state_d = S_IDLE;
					end else if (cnt_q == (is_cfg_q ? LAST_CFG : LAST_DISP)) begin
						state_d = S_CHECK;
					end
				end
			end
			S_CHECK: begin
				state_d = S_IDLE;
				if (!fields_ok) begin
					st_set[ST_BAD_FIELD] = 1'b1;
				end else if (!is_cfg_q) begin
					ovr_d = buf_q[2][3:0];
					st_set[ST_DISP_DONE] = 1'b1;
				end else if (!wr_f && name_empty) begin
					sel_idx_d = 8'h00;
					sel_valid_d = 1'b1;
					st_set[ST_CFG_DONE] = 1'b1;
				end else begin
					lookup_req_d = 1'b1;
					state_d = S_LOOKUP;
				end
			end
			S_LOOKUP: begin
				if (lookup_ack_i) begin
					state_d = S_IDLE;
					if (wr_f && lookup_rsp_i.found && lookup_rsp_i.alterable && lookup_rsp_i.vtype == type_f &&
						len_ok) begin
						var_wr_vld_d = 1'b1;
						var_wr_d = '{idx: lookup_rsp_i.idx, vtype: type_f, len: eff_len, bytes: val_bytes, ival: ival};
						sel_idx_d = lookup_rsp_i.idx;
						sel_valid_d = 1'b1;
						st_set[ST_CFG_DONE] = 1'b1;
					end else if (!wr_f && lookup_rsp_i.found) begin
						sel_idx_d = lookup_rsp_i.idx;
						sel_valid_d = 1'b1;
						st_set[ST_CFG_DONE] = 1'b1;
					end else begin
						st_set[ST_REJECT] = 1'b1;
					end
				end
			end
			default: state_d = S_IDLE;
		endcase
		pg_rdy_d = ctrl_q[0] && (state_d == S_IDLE || state_d == S_COLLECT);
	end

	// Display character for the panel scanner, registered
	always_comb begin
		if (disp_col_i >= 5'(LINE_CHARS)) begin
			disp_char_d = CHAR_BLANK;
		end else if (ovr_q[3 - disp_line_i]) begin
			disp_char_d = disp_q[7'(disp_line_i) * 7'(LINE_CHARS) + 7'(disp_col_i)];
		end else if (disp_line_i == 2'h1) begin
			disp_char_d = CHAR_BLANK;
		end else begin
			disp_char_d = int_char_i;
		end
	end

	// APB slave: one wait state, writes land on the edge that completes the access
	always_comb begin
		pready_d = psel_i && penable_i && !pready_q;
		// Error flag lives only in the answer cycle, so the output needs no gate
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		ctrl_d = ctrl_q;
		status_d = status_q;
		if (psel_i && penable_i && !pready_q) begin
			pslverr_d = 1'b0;
			prdata_d = 32'h0000_0000;
			case (paddr_i)
				OFF_CTRL: prdata_d = ctrl_q;
				OFF_STATUS: prdata_d = {26'h000_0000, status_q};
				OFF_SEL: prdata_d = {23'h00_0000, sel_valid_q, sel_idx_q};
				OFF_OVR: prdata_d = {28'h000_0000, ovr_q};
				default: pslverr_d = 1'b1;
			endcase
		end
		if (psel_i && penable_i && pready_q && pwrite_i) begin
			if (paddr_i == OFF_CTRL) begin
				ctrl_d = {31'h0000_0000, pwdata_i[0]};
			end
			if (paddr_i == OFF_STATUS) begin
				status_d = status_q & ~pwdata_i[5:0];
			end
		end
		// A new event beats a clear in the same cycle
		status_d = status_d | st_set;
	end

	// Registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= S_IDLE;
			cnt_q <= 7'h00;
			is_cfg_q <= 1'b0;
			ovr_q <= 4'h0;
			ctrl_q <= CTRL_RST;
			status_q <= STATUS_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			pg_rdy_q <= 1'b0;
			lookup_req_q <= 1'b0;
			name_q <= '0;
			var_wr_vld_q <= 1'b0;
			var_wr_q <= '0;
			sel_idx_q <= 8'h00;
			sel_valid_q <= 1'b0;
			disp_char_q <= 8'h00;
			for (int i = 0; i < BUF_BYTES; i++) begin
				buf_q[i] <= 8'h00;
			end
			for (int i = 0; i < LINES*LINE_CHARS; i++) begin
				disp_q[i] <= 8'h00;
			end
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			is_cfg_q <= is_cfg_d;
			ovr_q <= ovr_d;
			ctrl_q <= ctrl_d;
			status_q <= status_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			pg_rdy_q <= pg_rdy_d;
			lookup_req_q <= lookup_req_d;
			name_q <= name_d;
			var_wr_vld_q <= var_wr_vld_d;
			var_wr_q <= var_wr_d;
			sel_idx_q <= sel_idx_d;
			sel_valid_q <= sel_valid_d;
			disp_char_q <= disp_char_d;
			buf_q <= buf_d;
			disp_q <= disp_d;
		end
	end

	// Outputs straight from flops
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign pg_rdy_o = pg_rdy_q;
	assign lookup_req_o = lookup_req_q;
	assign lookup_name_o = name_q;
	assign var_wr_vld_o = var_wr_vld_q;
	assign var_wr_o = var_wr_q;
	assign sel_idx_o = sel_idx_q;
	assign sel_valid_o = sel_valid_q;
	assign disp_char_o = disp_char_q;

	// Checks next to the logic
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_apb_wait_one: assert property (psel_i && penable_i && !pready_q |=> pready_q)
		else $error("APB access not answered after one wait");
	a_flags_taken: assert property (state_q == S_CHECK && !is_cfg_q && fields_ok |=>
		ovr_q == $past(buf_q[2][3:0]) && status_q[ST_DISP_DONE])
		else $error("Override flags not taken from byte 2");
	a_disp_len_bad: assert property (state_q == S_COLLECT && accept && !pg_first_i && cnt_q == POS_LEN &&
		!is_cfg_q && pg_byte_i != LEN_DISP |=> status_q[ST_BAD_LEN] && state_q == S_IDLE)
		else $error("Bad display length accepted");
	a_cfg_len_bad: assert property (state_q == S_COLLECT && accept && !pg_first_i && cnt_q == POS_LEN &&
		is_cfg_q && pg_byte_i != LEN_CFG |=> status_q[ST_BAD_LEN] && state_q == S_IDLE)
		else $error("Bad configuration length accepted");
	a_line_two_blank: assert property (!ovr_q[2] && disp_line_i == 2'h1 |=> disp_char_o == CHAR_BLANK)
		else $error("Line two default not blank");
	a_host_text: assert property (ovr_q[3] && disp_line_i == 2'h0 && disp_col_i < 5'd20 |=>
		disp_char_o == $past(disp_q[disp_col_i]))
		else $error("Host text not shown on line one");
	a_own_text: assert property (!ovr_q[3] && disp_line_i == 2'h0 && disp_col_i < 5'd20 |=>
		disp_char_o == $past(int_char_i))
		else $error("Internal text not shown on line one");
	a_alter_gated: assert property (var_wr_vld_o |-> $past(lookup_rsp_i.found && lookup_rsp_i.alterable &&
		lookup_ack_i && state_q == S_LOOKUP && len_ok &&
		lookup_rsp_i.vtype == type_f && wr_f, 1))
		else $error("Alteration without valid lookup");
	a_empty_first: assert property (state_q == S_CHECK && is_cfg_q && fields_ok && !wr_f && name_empty |=>
		sel_idx_o == 8'h00 && sel_valid_o && !lookup_req_o)
		else $error("Empty name did not select first variable");
	a_select_kept: assert property (state_q == S_LOOKUP && lookup_ack_i && !wr_f && lookup_rsp_i.found |=>
		sel_idx_o == $past(lookup_rsp_i.idx) && !var_wr_vld_o)
		else $error("Selection not recorded");
	a_type_reject: assert property (state_q == S_LOOKUP && lookup_ack_i && wr_f && lookup_rsp_i.vtype != type_f |=>
		!var_wr_vld_o && status_q[ST_REJECT])
		else $error("Type mismatch not rejected");
endmodule : mpdc_parser

// ==== tb/mpdc_host_model.sv ====
`timescale 1ns/1ps
module mpdc_host_model (
	input wire logic clk_i,
	input wire logic pg_rdy_i,
	output logic pg_vld_o,
	output logic pg_first_o,
	output logic [7:0] pg_byte_o,
	input wire logic lookup_req_i,
	input wire logic [159:0] lookup_name_i,
	output logic lookup_ack_o,
	output mpdc_pkg::mpdc_lookup_t lookup_rsp_o
);
	import mpdc_pkg::*;
	logic [7:0] pg_q [0:83];
	logic [4:0] req_sh_q;
	int ack_dly = 1;
	initial begin
		pg_vld_o = 1'b0;
		pg_first_o = 1'b0;
		pg_byte_o = 8'h00;
	end
	// Stream one page; the bench never repeats a page within one list
	task send(input int n);
		for (int k = 0; k < n; k++) begin
			pg_vld_o <= 1'b1;
			pg_first_o <= (k == 0);
			pg_byte_o <= pg_q[k];
			do @(posedge clk_i); while (pg_rdy_i !== 1'b1);
		end
		pg_vld_o <= 1'b0;
		pg_first_o <= 1'b0;
		pg_byte_o <= ~pg_q[n-1]; // Released line must not look like the last byte
	endtask : send
	// Name table: A alterable unsigned, B alterable signed, C read-only byte array; answer delay adjustable
	always @(posedge clk_i) begin
		req_sh_q <= {req_sh_q[3:0], lookup_req_i};
		lookup_ack_o <= req_sh_q[ack_dly];
		if (lookup_name_i == {8'h41, 152'h0}) begin
			lookup_rsp_o <= '{1'b1, 1'b1, 8'h05, TY_UINT};
		end else if (lookup_name_i == {8'h42, 152'h0}) begin
			lookup_rsp_o <= '{1'b1, 1'b1, 8'h07, TY_SINT};
		end else if (lookup_name_i == {8'h43, 152'h0}) begin
			lookup_rsp_o <= '{1'b1, 1'b0, 8'h09, TY_BYTES};
		end else begin
			lookup_rsp_o <= '0;
		end
	end
endmodule : mpdc_host_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import mpdc_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, er, pg_vld, pg_first, pg_rdy, lreq, lack, wr_vld, sel_vld;
	logic [7:0] pg_byte, sel_idx, dchar, ichar = 8'h55;
	logic [159:0] lname;
	logic [1:0] dline = 2'h0;
	logic [4:0] dcol = 5'h00;
	mpdc_lookup_t lrsp;
	mpdc_var_wr_t wr;
	int err_count = 0, compares = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	mpdc_parser i_mpdc_parser (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pg_vld_i(pg_vld), .pg_first_i(pg_first), .pg_byte_i(pg_byte), .pg_rdy_o(pg_rdy),
		.lookup_req_o(lreq), .lookup_name_o(lname), .lookup_ack_i(lack), .lookup_rsp_i(lrsp),
		.var_wr_vld_o(wr_vld), .var_wr_o(wr), .sel_idx_o(sel_idx), .sel_valid_o(sel_vld),
		.disp_line_i(dline), .disp_col_i(dcol), .int_char_i(ichar), .disp_char_o(dchar));
	mpdc_host_model i_mpdc_host_model (.clk_i(clk_i), .pg_rdy_i(pg_rdy), .pg_vld_o(pg_vld),
		.pg_first_o(pg_first), .pg_byte_o(pg_byte), .lookup_req_i(lreq), .lookup_name_i(lname),
		.lookup_ack_o(lack), .lookup_rsp_o(lrsp));
	task report_and_stop;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	// Hang guard, well above the several hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One APB transfer; held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	// Check status then clear it with write-one-to-clear
	task status(input logic [5:0] e);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk("status", {26'h0, e}, rd);
		apb(1'b1, OFF_STATUS, 32'h0000_003F);
	endtask : status
	task page(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
		for (int k = 0; k < 84; k++) i_mpdc_host_model.pg_q[k] = 8'h00;
		i_mpdc_host_model.pg_q[0] = b0;
		i_mpdc_host_model.pg_q[1] = b1;
		i_mpdc_host_model.pg_q[2] = b2;
	endtask : page
	task scan(input logic [1:0] l, input logic [4:0] c, input logic [7:0] e);
		dline <= l;
		dcol <= c;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("disp_char", {24'h0, e}, {24'h0, dchar});
		@(posedge clk_i);
	endtask : scan
	// Wait for the alteration strobe, bounded
	task wait_wr;
		int n;
		n = 0;
		while (wr_vld !== 1'b1 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		chk("var_wr_vld", 32'h1, {31'h0, wr_vld});
	endtask : wait_wr
	task t_regs;
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk("ctrl", CTRL_RST, rd);
		apb(1'b0, 12'h0F0, 32'h0000_0000);
		chk("unmapped err", 32'h1, {31'h0, er});
	endtask : t_regs
	task t_display;
		page(8'h22, 8'h52, 8'h09, 84);
		i_mpdc_host_model.pg_q[4] = 8'h48;
		i_mpdc_host_model.pg_q[5] = 8'h49;
		i_mpdc_host_model.pg_q[7] = 8'h58; // Beyond the zero: must not show
		i_mpdc_host_model.pg_q[64] = 8'h4F;
		i_mpdc_host_model.send(84);
		status(6'h01);
		apb(1'b0, OFF_OVR, 32'h0000_0000);
		chk("override", 32'h0000_0009, rd);
		scan(2'h0, 5'h00, 8'h48);
		scan(2'h0, 5'h03, CHAR_BLANK);
		scan(2'h1, 5'h00, CHAR_BLANK);
		ichar <= 8'h2A;
		scan(2'h2, 5'h00, 8'h2A);
		scan(2'h3, 5'h00, 8'h4F);
	endtask : t_display
	task t_bad_header;
		page(8'h22, 8'h51, 8'h00, 2);
		i_mpdc_host_model.send(2);
		status(6'h08);
		page(8'h62, 8'h52, 8'h00, 2);
		i_mpdc_host_model.send(2);
		status(6'h04);
	endtask : t_bad_header
	task t_cfg_alter;
		page(8'h3D, 8'h28, 8'hE2, 42);
		i_mpdc_host_model.pg_q[4] = 8'h41;
		i_mpdc_host_model.pg_q[25] = 8'h12;
		i_mpdc_host_model.pg_q[26] = 8'h34;
		i_mpdc_host_model.ack_dly = 4;
		i_mpdc_host_model.send(42);
		wait_wr();
		chk("var_wr ival", 32'h0000_1234, wr.ival);
		chk("var_wr idx", 32'h0000_0005, {24'h0, wr.idx});
		@(posedge clk_i);
		status(6'h02);
		chk("sel_idx", 32'h0000_0005, {24'h0, sel_idx});
		i_mpdc_host_model.ack_dly = 1;
		page(8'h3D, 8'h28, 8'hC2, 42);
		i_mpdc_host_model.pg_q[4] = 8'h41;
		i_mpdc_host_model.send(42);
		repeat (12) @(posedge clk_i);
		status(6'h20);
		// Signed one-byte value, sign bit set
		page(8'h3D, 8'h28, 8'hC1, 42);
		i_mpdc_host_model.pg_q[4] = 8'h42;
		i_mpdc_host_model.pg_q[25] = 8'h80;
		i_mpdc_host_model.send(42);
		wait_wr();
		chk("var_wr sint", 32'hFFFF_FF80, wr.ival);
		chk("var_wr idx", 32'h0000_0007, {24'h0, wr.idx});
		@(posedge clk_i);
		status(6'h02);
		// Read-only variable: alteration refused, selection kept
		page(8'h3D, 8'h28, 8'hA2, 42);
		i_mpdc_host_model.pg_q[4] = 8'h43;
		i_mpdc_host_model.send(42);
		repeat (12) @(posedge clk_i);
		status(6'h20);
		chk("sel_idx kept", 32'h0000_0007, {24'h0, sel_idx});
	endtask : t_cfg_alter
	task t_cfg_select;
		page(8'h3D, 8'h28, 8'h00, 42);
		i_mpdc_host_model.send(42);
		repeat (6) @(posedge clk_i);
		status(6'h02);
		chk("sel_valid", 32'h1, {31'h0, sel_vld});
		chk("sel_idx first", 32'h0, {24'h0, sel_idx});
		page(8'h3D, 8'h28, 8'h00, 42);
		i_mpdc_host_model.pg_q[41] = 8'h01;
		i_mpdc_host_model.send(42);
		repeat (6) @(posedge clk_i);
		status(6'h10);
		page(8'h3D, 8'h28, 8'h00, 42);
		i_mpdc_host_model.pg_q[4] = 8'h42;
		i_mpdc_host_model.send(42);
		repeat (12) @(posedge clk_i);
		status(6'h02);
		chk("sel_idx named", 32'h0000_0007, {24'h0, sel_idx});
		page(8'h3D, 8'h27, 8'h00, 2);
		i_mpdc_host_model.send(2);
		status(6'h08);
	endtask : t_cfg_select
	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_regs();
		t_display();
		t_bad_header();
		t_cfg_alter();
		t_cfg_select();
		report_and_stop();
	end
endmodule : testbench
